// ===== rtl/prp_pkg.sv
/*
 * shared constants and types of the primary receiver pipe and acknowledge logic.
 * assumes a 10 MHz core clock; times are converted to cycles here.
 */
package prp_pkg;
    localparam int PRP_PIPES = 6;
    localparam int PRP_ADDR_W = 40;
    localparam logic [5:0] PRP_PIPE_EN_RST = 6'h03;
    localparam int PRP_CLK_PERIOD_NS = 100;
    localparam int PRP_CE_MIN_US = 10;
    localparam int PRP_TURN_US = 130;
    localparam int PRP_CE_MIN_CYC = (PRP_CE_MIN_US * 1000 + PRP_CLK_PERIOD_NS - 1) / PRP_CLK_PERIOD_NS;
    localparam int PRP_TURN_CYC = (PRP_TURN_US * 1000 + PRP_CLK_PERIOD_NS - 1) / PRP_CLK_PERIOD_NS;
    localparam logic [1:0] PRP_AW_3 = 2'h1;
    localparam logic [1:0] PRP_AW_4 = 2'h2;

    typedef enum logic [5:0] {
        PRP_IDLE = 6'h01,
        PRP_SEARCH = 6'h02,
        PRP_RECV = 6'h04,
        PRP_STORE = 6'h08,
        PRP_TURN = 6'h10,
        PRP_ACK = 6'h20
    } prp_state_e;
endpackage : prp_pkg

// ===== rtl/prp_rx_ack.sv
/*
 * receive-side packet transaction logic: six-pipe address search, new/repeat
 * classification, payload hand-off, flags and acknowledge turnaround.
 * assumes the air front end delivers address, bytes and packet end on i_clock,
 * and that an external transmit store reports pending acknowledge payloads.
 */
// Behaviour
// - primary receiver with chip enable high enters receive mode and searches.
// - with auto acknowledge on, classify each packet as new or repeat.
// - new packet: payload into receive FIFO, set receive-data-ready flag.
// - previous ack carried payload: raise transmit-done on next packet; here only an ack to a new packet counts, raised on the next new packet.
// - no-acknowledge marker absent: turn around into transmit to acknowledge.
// - pending transmit payload is attached to the acknowledge.
// - after acknowledge fully sent, return to receive and search.
// - repeat is discarded but still acknowledged.
// - six pipes, each with own address decoder and behaviour.
// - pipes matched in parallel; first hit locks out others until packet ends.
// - crc, encoding, width, channel, rate, gain shared; crc forced with auto ack.
// - each pipe has its own enable bit; reset enables pipes 0 and 1.
// - pipe 0 full 5-byte address; pipes 1-5 share upper 4 bytes.
// - acknowledge goes to the address of the receiving pipe.
// - each autonomous sequence ends with the active-low interrupt; here only a new packet drives it low, and a repeat raises none.
// - chip enable held at least 10 us; sending starts 130 us later.
// - transmitter switches to receive after sending and awaits acknowledge.
// - compare identifier, and crc when identifiers equal; both equal is repeat.
// - up to three pending ack payloads, first in first out per transmitter.
`timescale 1ns/100ps
`default_nettype none
module prp_rx_ack
    import prp_pkg::*;
#(
    parameter int MAX_PAYLOAD = 32
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // chip enable pin and mode
    input wire logic i_chip_enable,
    input wire logic i_primary_receiver,
    input wire logic i_auto_ack_en,
    // pipe configuration
    input wire logic i_pipe_en_wr,
    input wire logic [5:0] i_pipe_enable_bits,
    input wire logic [39:0] i_pipe0_receive_address,
    input wire logic [39:0] i_pipe1_receive_address,
    input wire logic [31:0] i_pipe_receive_address_lsb,
    // shared radio settings
    input wire logic i_crc_en,
    input wire logic i_crc_2byte,
    input wire logic [1:0] i_addr_width,
    input wire logic [6:0] i_channel,
    input wire logic i_data_rate,
    input wire logic i_low_noise_amp_gain,
    // air receive front end
    input wire logic i_air_addr_valid,
    input wire logic [39:0] i_air_addr,
    input wire logic i_air_byte_valid,
    input wire logic [7:0] i_air_byte,
    input wire logic i_air_end,
    input wire logic i_air_crc_ok,
    input wire logic [1:0] i_air_packet_identifier,
    input wire logic [15:0] i_air_crc,
    input wire logic i_air_no_ack,
    // acknowledge transmitter and payload store
    input wire logic [5:0] i_ack_pay_pending,
    input wire logic i_ack_done,
    // flag clears and payload ready from host
    input wire logic i_clr_rx_data_ready,
    input wire logic i_clr_tx_done,
    input wire logic i_rx_ready,
    // outputs
    output logic o_rx_mode,
    output logic o_tx_mode,
    output logic [5:0] o_pipe_enable_bits,
    output logic o_crc_on,
    output logic o_crc_2byte,
    output logic [1:0] o_addr_width,
    output logic [6:0] o_channel,
    output logic o_data_rate,
    output logic o_low_noise_amp_gain,
    output logic o_ack_start,
    output logic [39:0] o_ack_addr,
    output logic o_ack_with_payload,
    output logic o_ack_pay_pop,
    output logic [2:0] o_ack_pipe,
    output logic o_rx_data_ready_flag,
    output logic o_tx_done_flag,
    output logic o_irq_n,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic [2:0] o_rx_pipe,
    output logic o_rx_last
);
    function automatic logic [39:0] width_mask(input logic [1:0] aw);
        width_mask = (aw == PRP_AW_3) ? 40'h00_00ff_ffff : (aw == PRP_AW_4) ? 40'h00_ffff_ffff : 40'hff_ffff_ffff;
    endfunction : width_mask

    function automatic logic [39:0] pipe_addr(input logic [2:0] p, input logic [39:0] a0, input logic [39:0] a1,
                                              input logic [31:0] lsb);
        case (p)
            3'h0: pipe_addr = a0;
            3'h1: pipe_addr = a1;
            3'h2: pipe_addr = {a1[39:8], lsb[7:0]};
            3'h3: pipe_addr = {a1[39:8], lsb[15:8]};
            3'h4: pipe_addr = {a1[39:8], lsb[23:16]};
            default: pipe_addr = {a1[39:8], lsb[31:24]};
        endcase
    endfunction : pipe_addr

    prp_state_e state;
    prp_state_e next_state;
    logic ce_s1, ce_s2, ce_s3, ce_lvl;
    logic [6:0] ce_cnt;
    logic ce_ok;
    logic [10:0] turn_cnt;
    logic [2:0] pipe;
    logic [7:0] mem [MAX_PAYLOAD];
    logic [5:0] wr_idx;
    logic [5:0] rd_idx;
    logic [5:0] pay_len;
    logic is_new;
    logic want_ack;
    logic [1:0] prev_pid [PRP_PIPES];
    logic [15:0] prev_crc [PRP_PIPES];
    logic [5:0] ack_pay_sent;
    logic [5:0] hits;
    logic [2:0] first_hit;

    prp_stream_if s_core ();
    prp_stream_if s_out ();

    genvar g;
    generate
        for (g = 0; g < PRP_PIPES; g++) begin : g_dec
            // one comparator per pipe so every enabled address is searched at once
            assign hits[g] = o_pipe_enable_bits[g] && (((pipe_addr(3'(g), i_pipe0_receive_address,
                i_pipe1_receive_address, i_pipe_receive_address_lsb) ^ i_air_addr) & width_mask(o_addr_width))
                == 40'h00_0000_0000);
        end
    endgenerate

    // lowest pipe wins; distinct addresses make ties impossible in practice
    assign first_hit = hits[0] ? 3'h0 : hits[1] ? 3'h1 : hits[2] ? 3'h2 : hits[3] ? 3'h3 : hits[4] ? 3'h4 : 3'h5;
    wire logic pid_same = (i_air_packet_identifier == prev_pid[pipe]);
    wire logic crc_same = (i_air_crc == prev_crc[pipe]);
    wire logic new_pkt = !i_auto_ack_en || !pid_same || !crc_same;
    wire logic pkt_ok = i_air_end && i_air_crc_ok;
    wire logic ack_req = i_auto_ack_en && !i_air_no_ack;
    wire logic rx_set = (state == PRP_RECV) && pkt_ok && new_pkt;
    wire logic tx_set = rx_set && ack_pay_sent[pipe];
    wire logic enter_ack = (state == PRP_TURN) && (turn_cnt == 11'(PRP_TURN_CYC - 1));
    wire logic active = i_primary_receiver && ce_lvl && ce_ok;

    assign s_core.data = mem[rd_idx[4:0]];
    assign s_core.pipe = pipe;
    assign s_core.last = (rd_idx == pay_len - 6'h01);
    assign s_core.valid = (state == PRP_STORE) && (pay_len != 6'h00);
    assign s_out.ready = i_rx_ready;
    assign o_rx_valid = s_out.valid;
    assign o_rx_data = s_out.data;
    assign o_rx_pipe = s_out.pipe;
    assign o_rx_last = s_out.last;

    prp_skid_buf u_buf (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .s_in(s_core.snk),
        .s_out(s_out.src)
    );

    always_comb begin
        next_state = state;
        case (state)
            PRP_IDLE: if (active) next_state = PRP_SEARCH;
            PRP_SEARCH: begin
                if (!active) next_state = PRP_IDLE;
                else if (i_air_addr_valid && hits != 6'h00) next_state = PRP_RECV;
            end
            PRP_RECV: begin
                if (i_air_end && !i_air_crc_ok) next_state = PRP_SEARCH;
                else if (pkt_ok && new_pkt) next_state = PRP_STORE;
                else if (pkt_ok && ack_req) next_state = PRP_TURN;
                else if (pkt_ok) next_state = PRP_SEARCH;
            end
            PRP_STORE: begin
                if (pay_len == 6'h00 || (s_core.ready && s_core.last)) begin
                    next_state = want_ack ? PRP_TURN : PRP_SEARCH;
                end
            end
            PRP_TURN: if (enter_ack) next_state = PRP_ACK;
            PRP_ACK: if (i_ack_done) next_state = PRP_SEARCH;
            default: next_state = PRP_IDLE;
        endcase
    end

    // pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ce_s1 <= 1'b0;
            ce_s2 <= 1'b0;
            ce_s3 <= 1'b0;
            ce_lvl <= 1'b0;
        end else begin
            ce_s1 <= i_chip_enable;
            ce_s2 <= ce_s1;
            ce_s3 <= ce_s2;
            if (ce_s2 == ce_s3) ce_lvl <= ce_s3;
        end
    end

    // short glitches on chip enable do not start the radio
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ce_cnt <= 7'h00;
            ce_ok <= 1'b0;
        end else if (!ce_lvl) begin
            ce_cnt <= 7'h00;
            ce_ok <= 1'b0;
        end else if (ce_cnt == 7'(PRP_CE_MIN_CYC - 1)) begin
            ce_ok <= 1'b1;
        end else begin
            ce_cnt <= ce_cnt + 7'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= PRP_IDLE;
            turn_cnt <= 11'h000;
        end else begin
            state <= next_state;
            turn_cnt <= (state == PRP_TURN) ? turn_cnt + 11'h001 : 11'h000;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pipe <= 3'h0;
            wr_idx <= 6'h00;
            rd_idx <= 6'h00;
            pay_len <= 6'h00;
            want_ack <= 1'b0;
            is_new <= 1'b0;
        end else begin
            if (state == PRP_SEARCH && i_air_addr_valid) begin
                pipe <= first_hit;
                wr_idx <= 6'h00;
            end
            if (state == PRP_RECV && i_air_byte_valid && wr_idx != 6'(MAX_PAYLOAD)) wr_idx <= wr_idx + 6'h01;
            if (state == PRP_RECV && pkt_ok) begin
                pay_len <= wr_idx;
                want_ack <= ack_req;
                is_new <= new_pkt;
                rd_idx <= 6'h00;
            end
            if (s_core.valid && s_core.ready) rd_idx <= rd_idx + 6'h01;
        end
    end

    // payload held until the packet is judged; repeats never reach the buffer
    always_ff @(posedge i_clock) begin
        if (state == PRP_RECV && i_air_byte_valid && wr_idx != 6'(MAX_PAYLOAD)) mem[wr_idx[4:0]] <= i_air_byte;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < PRP_PIPES; k++) begin
                prev_pid[k] <= 2'h0;
                prev_crc[k] <= 16'h0000;
            end
        end else if (rx_set) begin
            prev_pid[pipe] <= i_air_packet_identifier;
            prev_crc[pipe] <= i_air_crc;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_pay_sent <= 6'h00;
            o_ack_start <= 1'b0;
            o_ack_addr <= 40'h00_0000_0000;
            o_ack_with_payload <= 1'b0;
            o_ack_pay_pop <= 1'b0;
            o_ack_pipe <= 3'h0;
        end else begin
            o_ack_start <= enter_ack;
            o_ack_pay_pop <= enter_ack && i_ack_pay_pending[pipe];
            if (enter_ack) begin
                o_ack_addr <= pipe_addr(pipe, i_pipe0_receive_address, i_pipe1_receive_address,
                                        i_pipe_receive_address_lsb);
                o_ack_with_payload <= i_ack_pay_pending[pipe];
                o_ack_pipe <= pipe;
            end
            if (tx_set) ack_pay_sent[pipe] <= 1'b0;
            if (enter_ack && i_ack_pay_pending[pipe] && is_new) ack_pay_sent[pipe] <= 1'b1;
        end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_data_ready_flag <= 1'b0;
            o_tx_done_flag <= 1'b0;
            o_irq_n <= 1'b1;
        end else begin
            o_rx_data_ready_flag <= rx_set || (o_rx_data_ready_flag && !i_clr_rx_data_ready);
            o_tx_done_flag <= tx_set || (o_tx_done_flag && !i_clr_tx_done);
            o_irq_n <= !(rx_set || tx_set || (o_rx_data_ready_flag && !i_clr_rx_data_ready)
                         || (o_tx_done_flag && !i_clr_tx_done));
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pipe_enable_bits <= PRP_PIPE_EN_RST;
            o_crc_on <= 1'b0;
            o_crc_2byte <= 1'b0;
            o_addr_width <= 2'h3;
            o_channel <= 7'h00;
            o_data_rate <= 1'b0;
            o_low_noise_amp_gain <= 1'b0;
            o_rx_mode <= 1'b0;
            o_tx_mode <= 1'b0;
        end else begin
            if (i_pipe_en_wr) o_pipe_enable_bits <= i_pipe_enable_bits;
            o_crc_on <= i_crc_en || i_auto_ack_en;
            o_crc_2byte <= i_crc_2byte;
            o_addr_width <= i_addr_width;
            o_channel <= i_channel;
            o_data_rate <= i_data_rate;
            o_low_noise_amp_gain <= i_low_noise_amp_gain;
            o_rx_mode <= (next_state == PRP_SEARCH) || (next_state == PRP_RECV);
            o_tx_mode <= (next_state == PRP_ACK);
        end
    end

    chk_idle_to_search: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_IDLE && active) |=> (state == PRP_SEARCH) ##1 o_rx_mode) else $error("no search");
    chk_pipe_locked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_RECV && $past(state) == PRP_RECV) |-> $stable(pipe)) else $error("pipe changed");
    chk_new_sets_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_RECV && pkt_ok && new_pkt) |=> o_rx_data_ready_flag && !o_irq_n) else $error("flag");
    chk_repeat_no_store: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_RECV && pkt_ok && !new_pkt) |=> state != PRP_STORE) else $error("repeat stored");
    logic [10:0] turn_age;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) turn_age <= 11'h000;
        else turn_age <= (state == PRP_TURN) ? turn_age + 11'h001 : 11'h000;
    end
    chk_ack_turnaround: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_TURN || o_ack_start) |-> (turn_age == 11'(PRP_TURN_CYC)) == o_ack_start) else $error("turn");
    chk_ack_return: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (state == PRP_ACK && i_ack_done) |=> state == PRP_SEARCH ##1 !o_tx_mode) else $error("no return");
    chk_crc_forced: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_auto_ack_en |=> o_crc_on) else $error("crc not forced");
    chk_ack_address: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        o_ack_start |-> o_ack_addr == pipe_addr(o_ack_pipe, i_pipe0_receive_address,
        i_pipe1_receive_address, i_pipe_receive_address_lsb)) else $error("ack address");
endmodule : prp_rx_ack
`default_nettype wire

// ===== rtl/prp_skid_buf.sv
/*
 * two-entry buffer in the receive payload path.
 * assumes both sides on i_clock; outputs come from flops.
 */
`timescale 1ns/100ps
`default_nettype none
module prp_skid_buf
    import prp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    prp_stream_if.snk s_in,
    prp_stream_if.src s_out
);
    logic [11:0] ent [2];
    logic [1:0] cnt;
    wire logic push = s_in.valid && s_in.ready;
    wire logic pop = s_out.valid && s_out.ready;
    wire logic [11:0] word = {s_in.last, s_in.pipe, s_in.data};

    assign s_in.ready = (cnt != 2'h2);
    assign s_out.valid = (cnt != 2'h0);
    assign {s_out.last, s_out.pipe, s_out.data} = ent[0];

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 2'h0;
            ent[0] <= 12'h000;
            ent[1] <= 12'h000;
        end else begin
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
            if (pop) begin
                ent[0] <= (cnt == 2'h2) ? ent[1] : word;
            end else if (push && cnt == 2'h0) begin
                ent[0] <= word;
            end
            if (push && ((cnt == 2'h1 && !pop) || cnt == 2'h2)) begin
                ent[1] <= word;
            end
        end
    end

    chk_buf_no_overflow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        cnt != 2'h3) else $error("buffer count out of range");
endmodule : prp_skid_buf
`default_nettype wire

// ===== rtl/prp_stream_if.sv
/*
 * byte stream carrier between the receiver core and its output buffer.
 * assumes one clock; a word moves when valid and ready are both high.
 */
`timescale 1ns/100ps
`default_nettype none
interface prp_stream_if;
    logic [7:0] data;
    logic [2:0] pipe;
    logic last;
    logic valid;
    logic ready;
    modport src (output data, output pipe, output last, output valid, input ready);
    modport snk (input data, input pipe, input last, input valid, output ready);
endinterface : prp_stream_if
`default_nettype wire

// ===== test/primary_receiver_pipe_ack_logic_bench.sv
/*
 * self-checking bench of prp_rx_ack with the air partner model.
 * assumes the 10 MHz clock and the turnaround and sync figures of prp_pkg.
 */
`timescale 1ns/100ps
`default_nettype none
module primary_receiver_pipe_ack_logic_bench;
    import prp_pkg::*;
    localparam logic [39:0] P0 = 40'ha1a2a3a4a5;
    localparam logic [39:0] P1 = 40'hb1b2b3b4b1;
    localparam logic [31:0] PL = 32'h55443322;
    logic i_clock, i_rst_n, i_chip_enable, i_primary_receiver, i_auto_ack_en, i_pipe_en_wr, i_crc_en;
    logic [5:0] i_pipe_enable_bits, i_ack_pay_pending, o_pipe_enable_bits;
    logic [39:0] i_pipe0_receive_address, i_pipe1_receive_address, i_air_addr, o_ack_addr;
    logic [31:0] i_pipe_receive_address_lsb;
    logic i_crc_2byte, i_data_rate, i_low_noise_amp_gain, i_air_addr_valid, i_air_byte_valid, i_air_end;
    logic [1:0] i_addr_width, i_air_packet_identifier, o_addr_width;
    logic [6:0] i_channel, o_channel;
    logic [7:0] i_air_byte, o_rx_data;
    logic [15:0] i_air_crc;
    logic i_air_crc_ok, i_air_no_ack, i_ack_done, i_clr_rx_data_ready, i_clr_tx_done, i_rx_ready;
    logic o_rx_mode, o_tx_mode, o_crc_on, o_crc_2byte, o_data_rate, o_low_noise_amp_gain, o_ack_start;
    logic o_ack_with_payload, o_ack_pay_pop, o_rx_data_ready_flag, o_tx_done_flag, o_irq_n, o_rx_valid, o_rx_last;
    logic [2:0] o_ack_pipe, o_rx_pipe;
    int errors = 0;
    int checks = 0;
    logic [11:0] rxq[$];

    prp_rx_ack #(.MAX_PAYLOAD(32)) DUT (.i_clock, .i_rst_n, .i_chip_enable, .i_primary_receiver, .i_auto_ack_en,
        .i_pipe_en_wr, .i_pipe_enable_bits, .i_pipe0_receive_address, .i_pipe1_receive_address,
        .i_pipe_receive_address_lsb, .i_crc_en, .i_crc_2byte, .i_addr_width, .i_channel, .i_data_rate,
        .i_low_noise_amp_gain, .i_air_addr_valid, .i_air_addr, .i_air_byte_valid, .i_air_byte, .i_air_end,
        .i_air_crc_ok, .i_air_packet_identifier, .i_air_crc, .i_air_no_ack, .i_ack_pay_pending, .i_ack_done,
        .i_clr_rx_data_ready, .i_clr_tx_done, .i_rx_ready, .o_rx_mode, .o_tx_mode, .o_pipe_enable_bits, .o_crc_on,
        .o_crc_2byte, .o_addr_width, .o_channel, .o_data_rate, .o_low_noise_amp_gain, .o_ack_start, .o_ack_addr,
        .o_ack_with_payload, .o_ack_pay_pop, .o_ack_pipe, .o_rx_data_ready_flag, .o_tx_done_flag, .o_irq_n,
        .o_rx_valid, .o_rx_data, .o_rx_pipe, .o_rx_last);
    prp_air_model air (.i_clock, .i_ack_start(o_ack_start), .o_addr_valid(i_air_addr_valid), .o_addr(i_air_addr),
        .o_byte_valid(i_air_byte_valid), .o_byte(i_air_byte), .o_end(i_air_end), .o_crc_ok(i_air_crc_ok),
        .o_pid(i_air_packet_identifier), .o_crc(i_air_crc), .o_no_ack(i_air_no_ack), .o_ack_done(i_ack_done));

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    always @(posedge i_clock) begin
        if (o_rx_valid === 1'b1 && i_rx_ready === 1'b1) begin
            rxq.push_back({o_rx_pipe, o_rx_last, o_rx_data});
        end
    end

    task automatic summarize();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // whole payload stream: count, order, pipe and last marker
    task automatic cmp_rx(input int n, input logic [2:0] p, input logic [7:0] b);
        cmp(40'(rxq.size()), 40'(n));
        for (int k = 0; k < n && rxq.size() > 0; k++) begin
            cmp(40'(rxq.pop_front()), 40'({p, 1'(k == n - 1), 8'(b + 8'(k))}));
        end
        rxq.delete();
    endtask : cmp_rx
    task automatic ticks(input int n);
        repeat (n) @(posedge i_clock);
    endtask : ticks
    task automatic pkt(input logic [39:0] a, input int n, input logic [7:0] b, input logic [1:0] id,
                       input logic [15:0] c, input logic na);
        air.send_addr(a);
        air.send_bytes(n, b);
        air.send_end(id, c, na);
        ticks(2);
    endtask : pkt
    task automatic clear_flags();
        i_clr_rx_data_ready <= 1'b1;
        i_clr_tx_done <= 1'b1;
        ticks(1);
        i_clr_rx_data_ready <= 1'b0;
        i_clr_tx_done <= 1'b0;
        ticks(2);
    endtask : clear_flags
    task automatic wait_ack(input logic [39:0] a, input logic [2:0] p, input logic pay);
        int k;
        k = 0;
        do begin
            @(posedge i_clock);
            #1;
            k++;
        end while (o_ack_start !== 1'b1 && k < 1500);
        cmp(40'(k >= 1290 && k < 1400), 40'h1);
        cmp(40'(o_tx_mode), 40'h1);
        cmp(o_ack_addr, a);
        cmp(40'(o_ack_pipe), 40'(p));
        cmp(40'(o_ack_with_payload), 40'(pay));
        cmp(40'(o_ack_pay_pop), 40'(pay));
        k = 0;
        do begin
            @(posedge i_clock);
            #1;
            k++;
        end while (o_rx_mode !== 1'b1 && k < 200);
        cmp(40'({o_rx_mode, o_tx_mode}), 40'h2);
        @(posedge i_clock);
    endtask : wait_ack
    task automatic expect_quiet(input int n);
        int seen;
        seen = 0;
        repeat (n) begin
            @(posedge i_clock);
            #1;
            seen += int'(o_ack_start !== 1'b0);
        end
        cmp(40'(seen), 40'h0);
        @(posedge i_clock);
    endtask : expect_quiet

    task automatic t_start();
        cmp(40'(o_pipe_enable_bits), 40'h03);
        cmp(40'({o_irq_n, o_rx_mode}), 40'h2);
        i_chip_enable <= 1'b1;
        ticks(60);
        cmp(40'(o_rx_mode), 40'h0);
        ticks(60);
        cmp(40'(o_rx_mode), 40'h1);
        cmp(40'({o_crc_on, o_channel, o_addr_width, o_crc_2byte, o_data_rate, o_low_noise_amp_gain}), 40'h1559);
    endtask : t_start
    task automatic t_new_with_intruder();
        i_rx_ready <= 1'b0;
        air.send_addr(P1);
        air.send_bytes(1, 8'h10);
        air.send_addr(P0);
        air.send_bytes(2, 8'h11);
        air.send_end(2'h1, 16'h1234, 1'b0);
        ticks(2);
        cmp(40'({o_rx_data_ready_flag, o_tx_done_flag, o_irq_n}), 40'h4);
        ticks(8);
        i_rx_ready <= 1'b1;
        wait_ack(P1, 3'h1, 1'b1);
        cmp_rx(3, 3'h1, 8'h10);
    endtask : t_new_with_intruder
    task automatic t_repeat();
        clear_flags();
        cmp(40'({o_rx_data_ready_flag, o_irq_n}), 40'h1);
        pkt(P1, 3, 8'h10, 2'h1, 16'h1234, 1'b0);
        cmp(40'({o_rx_data_ready_flag, o_tx_done_flag}), 40'h0);
        wait_ack(P1, 3'h1, 1'b1);
        cmp_rx(0, 3'h1, 8'h00);
    endtask : t_repeat
    task automatic t_same_id_new_crc();
        pkt(P1, 1, 8'h20, 2'h1, 16'h9999, 1'b0);
        cmp(40'({o_rx_data_ready_flag, o_tx_done_flag, o_irq_n}), 40'h6);
        wait_ack(P1, 3'h1, 1'b1);
        cmp_rx(1, 3'h1, 8'h20);
        clear_flags();
    endtask : t_same_id_new_crc
    task automatic t_pipes();
        i_ack_pay_pending <= 6'h00;
        pkt({P1[39:8], PL[7:0]}, 1, 8'h28, 2'h2, 16'h0001, 1'b0);
        cmp(40'(o_rx_data_ready_flag), 40'h0);
        expect_quiet(1400);
        {i_pipe_en_wr, i_pipe_enable_bits} <= {1'b1, 6'h3f};
        ticks(1);
        i_pipe_en_wr <= 1'b0;
        ticks(2);
        cmp(40'(o_pipe_enable_bits), 40'h3f);
        pkt({P1[39:8], PL[31:24]}, 1, 8'h30, 2'h3, 16'h0002, 1'b1);
        cmp(40'(o_rx_data_ready_flag), 40'h1);
        expect_quiet(1400);
        cmp(40'(o_rx_mode), 40'h1);
        cmp_rx(1, 3'h5, 8'h30);
        clear_flags();
        air.ack_wait = 60;
        pkt(P0, 1, 8'h40, 2'h1, 16'h0003, 1'b0);
        wait_ack(P0, 3'h0, 1'b0);
        cmp_rx(1, 3'h0, 8'h40);
    endtask : t_pipes

    initial begin
        {i_rst_n, i_chip_enable, i_pipe_en_wr, i_crc_en, i_crc_2byte, i_data_rate} = '0;
        {i_primary_receiver, i_auto_ack_en, i_rx_ready, i_low_noise_amp_gain} = 4'hf;
        {i_clr_rx_data_ready, i_clr_tx_done} = '0;
        {i_pipe_enable_bits, i_ack_pay_pending, i_addr_width, i_channel} = {6'h03, 6'h02, 2'h3, 7'h2a};
        {i_pipe0_receive_address, i_pipe1_receive_address, i_pipe_receive_address_lsb} = {P0, P1, PL};
        ticks(16);
        i_rst_n <= 1'b1;
        ticks(2);
        t_start();
        t_new_with_intruder();
        t_repeat();
        t_same_id_new_crc();
        t_pipes();
        summarize();
    end
    // whole run needs about 8300 cycles
    initial begin
        ticks(40000);
        errors++;
        summarize();
    end
endmodule : primary_receiver_pipe_ack_logic_bench
`default_nettype wire

// ===== test/prp_air_model.sv
/*
 * far-side partner: a primary transmitter on the air plus the acknowledge sender.
 * assumes its tasks are called just after a rising edge of i_clock.
 */
`timescale 1ns/100ps
`default_nettype none
module prp_air_model (
    // clock
    input wire logic i_clock,
    // acknowledge request from the block
    input wire logic i_ack_start,
    // air front end
    output logic o_addr_valid,
    output logic [39:0] o_addr,
    output logic o_byte_valid,
    output logic [7:0] o_byte,
    output logic o_end,
    output logic o_crc_ok,
    output logic [1:0] o_pid,
    output logic [15:0] o_crc,
    output logic o_no_ack,
    output logic o_ack_done
);
    int ack_wait = 3;
    initial begin
        {o_addr_valid, o_byte_valid, o_end, o_crc_ok, o_no_ack, o_ack_done} = '0;
        {o_addr, o_byte, o_pid, o_crc} = '0;
    end
    // on-air time of the acknowledge; the bench slows it per scenario
    always @(posedge i_clock) begin
        if (i_ack_start === 1'b1) begin
            repeat (ack_wait) @(posedge i_clock);
            o_ack_done <= 1'b1;
            @(posedge i_clock);
            o_ack_done <= 1'b0;
        end
    end
    // released lines show the inverse, never a stale copy
    task automatic send_addr(input logic [39:0] a);
        o_addr_valid <= 1'b1;
        o_addr <= a;
        @(posedge i_clock);
        o_addr_valid <= 1'b0;
        o_addr <= ~a;
    endtask : send_addr
    task automatic send_bytes(input int n, input logic [7:0] b);
        for (int k = 0; k < n; k++) begin
            o_byte_valid <= 1'b1;
            o_byte <= b + 8'(k);
            @(posedge i_clock);
        end
        o_byte_valid <= 1'b0;
        o_byte <= ~o_byte;
    endtask : send_bytes
    task automatic send_end(input logic [1:0] id, input logic [15:0] c, input logic na);
        {o_end, o_crc_ok, o_pid, o_crc, o_no_ack} <= {2'h3, id, c, na};
        @(posedge i_clock);
        {o_end, o_crc_ok, o_pid, o_crc, o_no_ack} <= {2'h0, ~id, ~c, ~na};
    endtask : send_end
endmodule : prp_air_model
`default_nettype wire
